// ==== common/prc_pkg.sv ====
// Purpose : Shared constants and types for the power and reset control block.
// Assumes : Registers are reached through the serial interface's internal register port.
// Notes   : Byte-wide registers at their printed addresses, one clock at 40 MHz.
`default_nettype none

package prc_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [6:0] PRC_ADDR_USER_CONTROL = 7'h6A;
  localparam logic [6:0] PRC_ADDR_POWER_MGMT_1 = 7'h6B;
  localparam logic [6:0] PRC_ADDR_POWER_MGMT_2 = 7'h6C;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PRC_UC_FIFO_ENABLE      = 6;
  localparam int PRC_UC_FIFO_RESET       = 2;
  localparam int PRC_UC_SIGNAL_CLEAR     = 0;
  localparam int PRC_PM1_DEVICE_RESET    = 7;
  localparam int PRC_PM1_SLEEP           = 6;
  localparam int PRC_PM1_CYCLE           = 5;
  localparam int PRC_PM1_GYRO_STANDBY    = 4;
  localparam int PRC_PM1_TEMP_OFF        = 3;
  localparam int PRC_PM1_CLOCK_SOURCE_SELECT_HI       = 2;
  localparam int PRC_PM2_ACCEL_HI        = 5;   // X at 5, Y at 4, Z at 3
  localparam int PRC_PM2_RATE_HI         = 2;   // X at 2, Y at 1, Z at 0

  // ----------------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] PRC_RST_USER_CONTROL = 8'h00;
  localparam logic [7:0] PRC_RST_POWER_MGMT_1 = 8'h01;  // Clock source code 001
  localparam logic [7:0] PRC_RST_POWER_MGMT_2 = 8'h00;
  localparam logic [7:0] PRC_MASK_USER_CTRL   = 8'h40;  // Stored bits only
  localparam logic [7:0] PRC_MASK_POWER_MGMT_1 = 8'h7F;
  localparam logic [7:0] PRC_MASK_POWER_MGMT_2 = 8'h3F;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int PRC_CLK_PERIOD_PS   = 25000;  // 40 MHz reference clock
  localparam int PRC_FIFO_RST_PS     = 50000;  // One period of the 20 MHz clock
  localparam int PRC_FIFO_RST_CYC    = (PRC_FIFO_RST_PS + PRC_CLK_PERIOD_PS - 1)
                                       / PRC_CLK_PERIOD_PS;
  localparam int PRC_DEV_RST_CYC     = 8;
  localparam int PRC_SIG_RST_CYC     = 4;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } prc_reg_wr_s;

  typedef enum logic [3:0] {
    PRC_ST_RUN   = 4'b0001,
    PRC_ST_SLEEP = 4'b0010,
    PRC_ST_DOZE  = 4'b0100,
    PRC_ST_WAKE  = 4'b1000
  } prc_mode_e;

endpackage : prc_pkg

`default_nettype wire

// ==== test/prc_host_model.sv ====
// Purpose : Host side of the register port: byte writes and reads.
// Assumes : Requests change just after a rising edge.
// Notes   : Released lines carry inverted values.
`default_nettype none

module prc_host_model
  import prc_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  output prc_reg_wr_s     o_reg_wr,
  output logic            o_reg_rd,
  output logic [6:0]      o_rd_addr
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero
  initial begin
    o_reg_wr = '0;
    o_reg_rd = 1'b0;
    o_rd_addr = 7'h00;
  end

  // One strobed byte; clock code kept at 001
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d, input int idle);
    @(posedge i_ref_clk);
    o_reg_wr <= '{1'b1, a, (a == PRC_ADDR_POWER_MGMT_1) ? {d[7:3], 3'h1} : d};
    @(posedge i_ref_clk);
    o_reg_wr <= '{1'b0, ~a, ~d};
    repeat (idle) @(posedge i_ref_clk);
    #1;
  endtask : write_reg

  // Answer stands for the cycle after the taking edge
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d, output logic ok);
    @(posedge i_ref_clk);
    o_reg_rd <= 1'b1;
    o_rd_addr <= a;
    @(posedge i_ref_clk);
    o_reg_rd <= 1'b0;
    o_rd_addr <= ~a;
    #1;
    ok = i_rvalid;
    d = i_rdata;
  endtask : read_reg
endmodule : prc_host_model

`default_nettype wire

// ==== test/prc_monitor.sv ====
// Purpose : Port checker for the power and reset control block.
// Assumes : Clock enable held high.
// Notes   : Helper counters measure reset pulses.
`default_nettype none

module prc_monitor
  import prc_pkg::*;
#(
  parameter int DEV_RST_CYCLES = 8,
  parameter int SIG_RST_CYCLES = 4
) (
  input wire logic        i_ref_clk,
  input wire logic        i_arst_n,
  input wire prc_reg_wr_s i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [6:0]  i_reg_rd_addr,
  input wire logic        i_sample_tick,
  input wire logic        i_temp_path_reset_req,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        o_reg_rvalid,
  input wire logic        o_fifo_enable,
  input wire logic        o_fifo_reset,
  input wire logic        o_device_reset,
  input wire logic        o_gyro_path_reset,
  input wire logic        o_temp_path_reset,
  input wire logic        o_sensor_data_clear,
  input wire logic        o_sleep_mode,
  input wire logic        o_wake_pulse,
  input wire logic        o_accel_sample_req,
  input wire logic        o_gyro_drive_en,
  input wire logic [2:0]  o_gyro_sense_en,
  input wire logic [2:0]  o_accel_en,
  input wire logic        o_temp_sensor_en,
  input wire logic [2:0]  o_clock_source_select
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] dev_len_q;
  logic [7:0] sig_len_q;
  logic       uc_wr;

  // User control write while o_device_reset is low
  assign uc_wr = i_reg_wr.en && (i_reg_wr.addr == PRC_ADDR_USER_CONTROL) && !o_device_reset;

  // High-time counters, zeroed so a cut pulse is not measured
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dev_len_q <= 8'h00;
      sig_len_q <= 8'h00;
    end else begin
      dev_len_q <= o_device_reset ? dev_len_q + 8'h01 : 8'h00;
      sig_len_q <= o_sensor_data_clear ? sig_len_q + 8'h01 : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);

  AST_READ_ANSWER: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("no read answer");
  AST_RESERVED_ZERO: assert property (
    o_reg_rvalid && $past(i_reg_rd_addr) == PRC_ADDR_USER_CONTROL |-> (o_reg_rdata & 8'hBA) == 8'h00)
    else $error("reserved bit set");
  AST_FIFO_ENABLE: assert property (
    uc_wr ##1 !uc_wr [*2] |=> o_fifo_enable == $past(i_reg_wr.data[PRC_UC_FIFO_ENABLE], 3))
    else $error("fifo enable wrong");
  AST_FIFO_PULSE: assert property (
    uc_wr && i_reg_wr.data[PRC_UC_FIFO_RESET] |->
    ##[1:2] $rose(o_fifo_reset) ##1 o_fifo_reset ##1 !o_fifo_reset)
    else $error("fifo pulse wrong");
  AST_DEV_LEN: assert property ($fell(o_device_reset) |-> dev_len_q == DEV_RST_CYCLES)
    else $error("device reset len");
  AST_SIG_LEN: assert property ($fell(o_sensor_data_clear) |-> sig_len_q == SIG_RST_CYCLES)
    else $error("signal clear len");
  AST_SIG_PATHS: assert property (
    o_sensor_data_clear |-> o_gyro_path_reset && o_temp_path_reset)
    else $error("path running");
  AST_PATH_ONLY: assert property (
    i_temp_path_reset_req && !o_gyro_path_reset |=> o_temp_path_reset && !o_sensor_data_clear)
    else $error("path reset wrong");
  AST_WAKE: assert property (
    o_wake_pulse |-> $past(i_sample_tick, 2) && !o_sleep_mode ##1 o_sleep_mode)
    else $error("wake not tied to tick");
  AST_SAMPLE: assert property (
    o_wake_pulse || o_accel_sample_req |->
    o_wake_pulse && (o_accel_sample_req == (o_accel_en != 3'h0)))
    else $error("sample request wrong");
  AST_SLEEP_OFF: assert property (
    o_sleep_mode |-> !o_gyro_drive_en && o_gyro_sense_en == 3'h0 && !o_temp_sensor_en)
    else $error("sensor on while asleep");
  AST_STANDBY: assert property (o_gyro_sense_en != 3'h0 |-> o_gyro_drive_en)
    else $error("sense on without drive");
  AST_CLOCK_SOURCE_SELECT: assert property ($rose(i_arst_n) |-> o_clock_source_select == 3'h1)
    else $error("clock code wrong");
endmodule : prc_monitor

bind prc_power_reset prc_monitor #(
  .DEV_RST_CYCLES(DEV_RST_CYCLES),
  .SIG_RST_CYCLES(SIG_RST_CYCLES)
) u_monitor (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_rd_addr(i_reg_rd_addr), .i_sample_tick(i_sample_tick),
  .i_temp_path_reset_req(i_temp_path_reset_req), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .o_fifo_enable(o_fifo_enable), .o_fifo_reset(o_fifo_reset),
  .o_device_reset(o_device_reset), .o_gyro_path_reset(o_gyro_path_reset),
  .o_temp_path_reset(o_temp_path_reset), .o_sensor_data_clear(o_sensor_data_clear),
  .o_sleep_mode(o_sleep_mode), .o_wake_pulse(o_wake_pulse),
  .o_accel_sample_req(o_accel_sample_req), .o_gyro_drive_en(o_gyro_drive_en),
  .o_gyro_sense_en(o_gyro_sense_en), .o_accel_en(o_accel_en),
  .o_temp_sensor_en(o_temp_sensor_en), .o_clock_source_select(o_clock_source_select)
);

`default_nettype wire

// ==== test/tb_top.sv ====
// Purpose : Self-checking bench for the power and reset control block.
// Assumes : Short reset lengths; clock enable tied high.
// Notes   : Each scenario task judges its own results.
`default_nettype none

`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin failures++; \
  $display("wrong value at %0t: %s", $time, msg); end end
`define WAITC(c) for (int w = 0; w < 64 && (c) !== 1'b1; w++) begin @(posedge clk); #1; end \
  if ((c) !== 1'b1) begin failures++; $display("wrong value at %0t: %s", $time, "timeout"); \
  conclude(); end

module tb_top
  import prc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int DEV_LEN = 6;
  localparam int SIG_LEN = 2;
  logic        clk, arst_n, tick, acc_req, tmp_req, rd, rvalid;
  logic [6:0]  rd_addr;
  prc_reg_wr_s wr;
  logic [7:0]  rdata, d;
  logic        ok, fifo_en, fifo_rst, dev_rst, gyro_rst, acc_rst, tmp_rst, clr;
  logic        sleep, wake, sample, gdrive, temp_en;
  logic [2:0]  gsense, acc_en, clk_sel;
  int          failures, checked;

  prc_power_reset #(.DEV_RST_CYCLES(DEV_LEN), .SIG_RST_CYCLES(SIG_LEN)) dut (
    .i_ref_clk(clk), .i_arst_n(arst_n), .i_clk_en(1'b1), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_rd_addr(rd_addr), .i_sample_tick(tick), .i_accel_path_reset_req(acc_req),
    .i_temp_path_reset_req(tmp_req), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .o_fifo_enable(fifo_en), .o_fifo_reset(fifo_rst), .o_device_reset(dev_rst),
    .o_gyro_path_reset(gyro_rst), .o_accel_path_reset(acc_rst), .o_temp_path_reset(tmp_rst),
    .o_sensor_data_clear(clr), .o_sleep_mode(sleep), .o_wake_pulse(wake),
    .o_accel_sample_req(sample), .o_gyro_drive_en(gdrive), .o_gyro_sense_en(gsense),
    .o_accel_en(acc_en), .o_temp_sensor_en(temp_en), .o_clock_source_select(clk_sel)
  );

  prc_host_model host (
    .i_ref_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_rd_addr(rd_addr)
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string m);
    host.read_reg(a, d, ok);
    `CHK(ok, 1'b1, m);
    `CHK(d, exp, m);
  endtask : rd_chk

  // Counts the edges a pulse stays high
  task automatic width_chk(ref logic s, input int exp, input string m);
    int n;
    `WAITC(s)
    for (n = 0; n < 40 && s === 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    `CHK(n, exp, m);
  endtask : width_chk

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_defaults();
    rd_chk(PRC_ADDR_USER_CONTROL, 8'h00, "uc reset");
    rd_chk(PRC_ADDR_POWER_MGMT_1, 8'h01, "pm1 reset");
    rd_chk(PRC_ADDR_POWER_MGMT_2, 8'h00, "pm2 reset");
    rd_chk(7'h10, 8'h00, "unmapped");
    `CHK(clk_sel, 3'h1, "clock source");
    `CHK({acc_en, gsense, temp_en}, 7'h7F, "sensors on");
    $display("test defaults done");
  endtask : t_defaults

  // Each standby bit, then reserved bits
  task automatic t_axes();
    for (int i = 0; i < 6; i++) begin
      host.write_reg(PRC_ADDR_POWER_MGMT_2, 8'h01 << i, 2);
      `CHK(acc_en, i > 2 ? ~(3'h1 << (i - 3)) : 3'h7, "accel axis");
      `CHK(gsense, i < 3 ? ~(3'h1 << i) : 3'h7, "gyro axis");
    end
    host.write_reg(PRC_ADDR_POWER_MGMT_2, 8'hFF, 2);
    rd_chk(PRC_ADDR_POWER_MGMT_2, 8'h3F, "pm2 reserved");
    host.write_reg(PRC_ADDR_POWER_MGMT_2, 8'h00, 2);
    host.write_reg(PRC_ADDR_USER_CONTROL, 8'hBA, 2);
    rd_chk(PRC_ADDR_USER_CONTROL, 8'h00, "uc reserved");
    $display("test axes done");
  endtask : t_axes

  task automatic t_resets();
    host.write_reg(PRC_ADDR_USER_CONTROL, 8'h44, 0);
    width_chk(fifo_rst, PRC_FIFO_RST_CYC, "fifo len");
    `CHK(fifo_en, 1'b1, "fifo on");
    rd_chk(PRC_ADDR_USER_CONTROL, 8'h40, "fifo clr");
    host.write_reg(PRC_ADDR_USER_CONTROL, 8'h01, 0);
    `WAITC(clr)
    `CHK({gyro_rst, acc_rst, tmp_rst, fifo_en}, 4'hE, "paths");
    `WAITC(clr === 1'b0)
    rd_chk(PRC_ADDR_USER_CONTROL, 8'h00, "clear done");
    @(posedge clk);
    acc_req <= 1'b1;
    tmp_req <= 1'b1;
    @(posedge clk);
    acc_req <= 1'b0;
    tmp_req <= 1'b0;
    #1;
    `CHK({acc_rst, tmp_rst, gyro_rst, clr}, 4'hC, "own path");
    $display("test resets done");
  endtask : t_resets

  task automatic t_power();
    host.write_reg(PRC_ADDR_POWER_MGMT_1, 8'h41, 2);
    `CHK({sleep, gdrive}, 2'h2, "sleep");
    host.write_reg(PRC_ADDR_POWER_MGMT_1, 8'h09, 2);
    `CHK({temp_en, gdrive}, 2'h1, "temp off");
    host.write_reg(PRC_ADDR_POWER_MGMT_1, 8'h11, 2);
    `CHK({gsense, gdrive}, 4'h1, "gyro standby");
    host.write_reg(PRC_ADDR_POWER_MGMT_1, 8'h21, 2);
    `WAITC(sleep)
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      `WAITC(wake)
      `CHK(sample, k == 0, "sample");
      host.write_reg(PRC_ADDR_POWER_MGMT_2, 8'h38, 2);
    end
    host.write_reg(PRC_ADDR_POWER_MGMT_1, 8'h01, 2);
    $display("test power done");
  endtask : t_power

  // Busy read, refused write, defaults
  task automatic t_device_reset();
    host.write_reg(PRC_ADDR_USER_CONTROL, 8'h40, 2);
    host.write_reg(PRC_ADDR_POWER_MGMT_2, 8'h05, 2);
    host.write_reg(PRC_ADDR_POWER_MGMT_1, 8'h80, 0);
    host.read_reg(PRC_ADDR_POWER_MGMT_1, d, ok);
    `CHK(d[7], 1'b1, "reset busy");
    host.write_reg(PRC_ADDR_POWER_MGMT_2, 8'h3F, 0);
    `WAITC(dev_rst === 1'b0)
    rd_chk(PRC_ADDR_USER_CONTROL, 8'h00, "uc default");
    rd_chk(PRC_ADDR_POWER_MGMT_1, 8'h01, "pm1 default");
    rd_chk(PRC_ADDR_POWER_MGMT_2, 8'h00, "pm2 default");
    host.write_reg(PRC_ADDR_POWER_MGMT_1, 8'h80, 0);
    width_chk(dev_rst, DEV_LEN, "dev len");
    $display("test device reset done");
  endtask : t_device_reset

  // Main sequence
  initial begin
    arst_n = 1'b0;
    tick = 1'b0;
    acc_req = 1'b0;
    tmp_req = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_defaults();
    t_axes();
    t_resets();
    t_power();
    t_device_reset();
    conclude();
  end
endmodule : tb_top

`default_nettype wire

// ==== verilog/prc_power_reset.sv ====
// Purpose : Power and reset control of a six-axis motion sensor: three control
//           registers, self-clearing resets, sleep, cycle, standby, axis enables.
// Assumes : Register port is the serial interface's internal byte port, synchronous.
// Notes   : Read data appears one cycle after the read strobe.
//
// Summary of operation
// R1: FIFO enable bit gates FIFO operation and access
// R2: FIFO reset bit pulses one 20 MHz period
// R3: Signal clear resets all paths, clears data
// R4: Device reset restores defaults, then self-clears
// R5: Sleep bit puts the chip to sleep
// R6: Cycle mode alternates doze and one accel sample
// R7: Cycle with no accel axes wakes, no sample
// R8: Gyro standby keeps drive, turns off sense
// R9: Temperature off bit disables temperature sensor
// R10: Clock source select resets to code 001
// R11: Host keeps clock source code 001
// R12: Accel axis off bits X, Y, Z
// R13: Gyro axis off bits X, Y, Z
// R14: Separate path resets leave sensor data intact
// R15: Reserved bits read zero, writes ignored
// R16: Self-clearing bits read one while busy
`default_nettype none

module prc_power_reset
  import prc_pkg::*;
#(
  parameter int DEV_RST_CYCLES = PRC_DEV_RST_CYC,
  parameter int SIG_RST_CYCLES = PRC_SIG_RST_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_clk_en,
  input  wire prc_reg_wr_s i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [6:0]  i_reg_rd_addr,
  input  wire logic        i_sample_tick,
  input  wire logic        i_accel_path_reset_req,
  input  wire logic        i_temp_path_reset_req,
  output logic [7:0]       o_reg_rdata,
  output logic             o_reg_rvalid,
  output logic             o_fifo_enable,
  output logic             o_fifo_reset,
  output logic             o_device_reset,
  output logic             o_gyro_path_reset,
  output logic             o_accel_path_reset,
  output logic             o_temp_path_reset,
  output logic             o_sensor_data_clear,
  output logic             o_sleep_mode,
  output logic             o_wake_pulse,
  output logic             o_accel_sample_req,
  output logic             o_gyro_drive_en,
  output logic [2:0]       o_gyro_sense_en,
  output logic [2:0]       o_accel_en,
  output logic             o_temp_sensor_en,
  output logic [2:0]       o_clock_source_select
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------

  // Counts a busy timer down and stops at zero
  function automatic logic [7:0] prc_dec(input logic [7:0] cnt);
    prc_dec = (cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
  endfunction : prc_dec

  // State to rest in when no wake is due
  function automatic prc_mode_e prc_rest(input logic sleep, input logic cyc_ok);
    if (sleep) begin
      prc_rest = PRC_ST_SLEEP;
    end else if (cyc_ok) begin
      prc_rest = PRC_ST_DOZE;
    end else begin
      prc_rest = PRC_ST_RUN;
    end
  endfunction : prc_rest

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  localparam logic [7:0] FIFO_LOAD = 8'(PRC_FIFO_RST_CYC);
  localparam logic [7:0] DEV_LOAD  = 8'(DEV_RST_CYCLES);
  localparam logic [7:0] SIG_LOAD  = 8'(SIG_RST_CYCLES);

  logic       fifo_en_q;
  logic [6:0] pm1_q;
  logic [5:0] pm2_q;
  logic [7:0] fifo_cnt_q;
  logic [7:0] dev_cnt_q;
  logic [7:0] sig_cnt_q;
  prc_mode_e  mode_q;
  prc_mode_e  mode_d;

  logic       dev_busy;
  logic       fifo_busy;
  logic       sig_busy;
  logic       wr_uc;
  logic       wr_pm1;
  logic       wr_pm2;
  logic       cyc_ok;
  logic       accel_any;

  // Decode of write strobes; writes are ignored during a device reset
  assign dev_busy  = (dev_cnt_q != 8'h00);
  assign fifo_busy = (fifo_cnt_q != 8'h00);
  assign sig_busy  = (sig_cnt_q != 8'h00);
  assign wr_uc     = i_reg_wr.en && !dev_busy && (i_reg_wr.addr == PRC_ADDR_USER_CONTROL);
  assign wr_pm1    = i_reg_wr.en && !dev_busy && (i_reg_wr.addr == PRC_ADDR_POWER_MGMT_1);
  assign wr_pm2    = i_reg_wr.en && !dev_busy && (i_reg_wr.addr == PRC_ADDR_POWER_MGMT_2);

  // Cycle mode only counts when neither sleep nor gyro standby is set
  assign cyc_ok    = pm1_q[PRC_PM1_CYCLE] && !pm1_q[PRC_PM1_SLEEP]
                     && !pm1_q[PRC_PM1_GYRO_STANDBY]; // [R6]
  assign accel_any = ~&pm2_q[PRC_PM2_ACCEL_HI -: 3];

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------

  // User control: only the FIFO enable bit is stored; reset bits live in timers
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fifo_en_q <= PRC_RST_USER_CONTROL[PRC_UC_FIFO_ENABLE];
    end else if (i_clk_en) begin
      if (dev_busy) begin
        fifo_en_q <= PRC_RST_USER_CONTROL[PRC_UC_FIFO_ENABLE]; // [R4]
      end else if (wr_uc) begin
        fifo_en_q <= i_reg_wr.data[PRC_UC_FIFO_ENABLE]; // [R1]
      end
    end
  end

  // Power management one: mode bits and clock source select
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pm1_q <= PRC_RST_POWER_MGMT_1[6:0]; // [R10]
    end else if (i_clk_en) begin
      if (dev_busy) begin
        pm1_q <= PRC_RST_POWER_MGMT_1[6:0]; // [R4] [R10]
      end else if (wr_pm1) begin
        pm1_q <= i_reg_wr.data[6:0] & PRC_MASK_POWER_MGMT_1[6:0];
      end
    end
  end

  // Power management two: per-axis off bits, reserved bits never stored
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pm2_q <= PRC_RST_POWER_MGMT_2[5:0];
    end else if (i_clk_en) begin
      if (dev_busy) begin
        pm2_q <= PRC_RST_POWER_MGMT_2[5:0]; // [R4]
      end else if (wr_pm2) begin
        pm2_q <= i_reg_wr.data[5:0] & PRC_MASK_POWER_MGMT_2[5:0]; // [R15]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Self-clearing reset timers
  // ----------------------------------------------------------------------

  // Device reset: a write of one loads the timer; writes while it runs are ignored
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dev_cnt_q <= 8'h00;
    end else if (i_clk_en) begin
      if (wr_pm1 && i_reg_wr.data[PRC_PM1_DEVICE_RESET]) begin
        dev_cnt_q <= DEV_LOAD; // [R4]
      end else begin
        dev_cnt_q <= prc_dec(dev_cnt_q); // [R4]
      end
    end
  end

  // FIFO reset: held for one 20 MHz period, then clears itself
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fifo_cnt_q <= 8'h00;
    end else if (i_clk_en) begin
      if (dev_busy) begin
        fifo_cnt_q <= 8'h00;
      end else if (wr_uc && i_reg_wr.data[PRC_UC_FIFO_RESET]) begin
        fifo_cnt_q <= FIFO_LOAD; // [R2]
      end else begin
        fifo_cnt_q <= prc_dec(fifo_cnt_q); // [R2]
      end
    end
  end

  // Full signal clear: resets all three paths and the data registers
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sig_cnt_q <= 8'h00;
    end else if (i_clk_en) begin
      if (dev_busy) begin
        sig_cnt_q <= 8'h00;
      end else if (wr_uc && i_reg_wr.data[PRC_UC_SIGNAL_CLEAR]) begin
        sig_cnt_q <= SIG_LOAD; // [R3]
      end else begin
        sig_cnt_q <= prc_dec(sig_cnt_q); // [R3]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power mode sequencer
  // ----------------------------------------------------------------------

  // Next mode; a wake lasts exactly one cycle before dozing again
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      PRC_ST_RUN: begin
        mode_d = prc_rest(pm1_q[PRC_PM1_SLEEP], cyc_ok); // [R5]
      end
      PRC_ST_SLEEP: begin
        mode_d = prc_rest(pm1_q[PRC_PM1_SLEEP], cyc_ok); // [R5]
      end
      PRC_ST_DOZE: begin
        if (cyc_ok && i_sample_tick) begin
          mode_d = PRC_ST_WAKE; // [R6]
        end else begin
          mode_d = prc_rest(pm1_q[PRC_PM1_SLEEP], cyc_ok);
        end
      end
      PRC_ST_WAKE: begin
        mode_d = prc_rest(pm1_q[PRC_PM1_SLEEP], cyc_ok); // [R6]
      end
      default: begin
        mode_d = PRC_ST_RUN;
      end
    endcase
  end

  // Mode register
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_q <= PRC_ST_RUN;
    end else if (i_clk_en) begin
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------------------------------------
  // Power and reset outputs
  // ----------------------------------------------------------------------

  // Reset lines follow the busy timers; registered to keep them glitch free
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_fifo_enable       <= 1'b0;
      o_fifo_reset        <= 1'b0;
      o_device_reset      <= 1'b0;
      o_gyro_path_reset   <= 1'b0;
      o_accel_path_reset  <= 1'b0;
      o_temp_path_reset   <= 1'b0;
      o_sensor_data_clear <= 1'b0;
    end else if (i_clk_en) begin
      o_fifo_enable       <= fifo_en_q; // [R1]
      o_fifo_reset        <= fifo_busy; // [R2]
      o_device_reset      <= dev_busy; // [R4]
      o_gyro_path_reset   <= sig_busy; // [R3]
      // Separate path requests touch only their own path, never the data
      o_accel_path_reset  <= sig_busy || i_accel_path_reset_req;               // [R3] [R14]
      o_temp_path_reset   <= sig_busy || i_temp_path_reset_req;                // [R3] [R14]
      o_sensor_data_clear <= sig_busy; // [R3] [R14]
    end
  end

  // Analog enables: one cycle behind the mode, which the front end tolerates
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sleep_mode          <= 1'b0;
      o_wake_pulse          <= 1'b0;
      o_accel_sample_req    <= 1'b0;
      o_gyro_drive_en       <= 1'b0;
      o_gyro_sense_en       <= 3'h0;
      o_accel_en            <= 3'h0;
      o_temp_sensor_en      <= 1'b0;
      o_clock_source_select <= PRC_RST_POWER_MGMT_1[2:0];
    end else if (i_clk_en) begin
      o_sleep_mode       <= (mode_q != PRC_ST_RUN) && (mode_q != PRC_ST_WAKE);  // [R5] [R6]
      o_wake_pulse       <= (mode_q == PRC_ST_WAKE);                            // [R7]
      o_accel_sample_req <= (mode_q == PRC_ST_WAKE) && accel_any;               // [R6] [R7]
      // Drive and PLL stay up in standby so the gyros restart quickly
      o_gyro_drive_en    <= (mode_q == PRC_ST_RUN);                             // [R8]
      if ((mode_q == PRC_ST_RUN) && !pm1_q[PRC_PM1_GYRO_STANDBY]) begin
        o_gyro_sense_en  <= ~pm2_q[PRC_PM2_RATE_HI -: 3];                       // [R8] [R13]
      end else begin
        o_gyro_sense_en  <= 3'h0;                                               // [R8]
      end
      if ((mode_q == PRC_ST_RUN) || (mode_q == PRC_ST_WAKE)) begin
        o_accel_en       <= ~pm2_q[PRC_PM2_ACCEL_HI -: 3];                      // [R12] [R7]
      end else begin
        o_accel_en       <= 3'h0;
      end
      o_temp_sensor_en   <= (mode_q == PRC_ST_RUN) && !pm1_q[PRC_PM1_TEMP_OFF]; // [R9]
      // The host is expected to leave code 001 here for full gyro accuracy
      o_clock_source_select <= pm1_q[PRC_PM1_CLOCK_SOURCE_SELECT_HI -: 3];                  // [R10] [R11]
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------

  // Registered read; reserved bits and unmapped addresses return zero
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else if (i_clk_en) begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        case (i_reg_rd_addr)
          PRC_ADDR_USER_CONTROL: begin
            o_reg_rdata <= {1'b0, fifo_en_q, 3'h0, fifo_busy, 1'b0, sig_busy}; // [R15] [R16]
          end
          PRC_ADDR_POWER_MGMT_1: begin
            o_reg_rdata <= {dev_busy, pm1_q}; // [R16]
          end
          PRC_ADDR_POWER_MGMT_2: begin
            o_reg_rdata <= {2'h0, pm2_q}; // [R15]
          end
          default: begin
            o_reg_rdata <= 8'h00;
          end
        endcase
      end
    end
  end

endmodule : prc_power_reset

`default_nettype wire
